// ### logic/bfcs_bus_cycle.sv
// One asynchronous flash bus cycle, write or read, timed in mclk cycles.
// Assumes start only while idle; read data arrives from an unclocked pin.
module bfcs_bus_cycle (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic wr,
	input wire logic [18:0] addr,
	input wire logic [15:0] wdata,
	input wire logic [15:0] pin_dq_i,
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic [18:0] addr_o,
	output logic [15:0] dq_o,
	output logic dq_oe,
	output logic [15:0] rdata,
	output logic done
);
	// =====================================================
	// State
	typedef struct packed {
		bfcs_pkg::bfcs_ph_t ph;
		logic [7:0] cnt;   // Strobe countdown
		logic wr;          // Cycle is a write
		logic ce_n, we_n, oe_n, dq_oe, done;
		logic [18:0] addr;
		logic [15:0] dq_o, rdata;
		logic [15:0] s1, s2; // Read data synchroniser
	} bfcs_bc_t;
	localparam bfcs_bc_t BC_RST = '{ph: bfcs_pkg::PH_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
		default: '0};
	bfcs_bc_t r, n;

	// =====================================================
	// Next state
	always_comb begin
		n = r;
		n.done = 1'b0;
		n.s1 = pin_dq_i;
		n.s2 = r.s1;
		case (r.ph)
			bfcs_pkg::PH_IDLE: if (start) begin
				// Address and data settle one cycle before any strobe
				n.ph = bfcs_pkg::PH_SETUP;
				n.wr = wr;
				n.addr = addr; // R5
				n.dq_o = wdata;
				n.ce_n = 1'b0;
				n.dq_oe = wr;
			end
			bfcs_pkg::PH_SETUP: begin
				n.ph = bfcs_pkg::PH_STROBE;
				if (r.wr) begin
					n.we_n = 1'b0;
					n.cnt = 8'(bfcs_pkg::WE_CYC - 1);
				end else begin
					// Output enable covers access plus synchroniser delay
					n.oe_n = 1'b0;
					n.cnt = 8'(bfcs_pkg::ACC_CYC + bfcs_pkg::SYNC_CYC - 1);
				end
			end
			bfcs_pkg::PH_STROBE: if (r.cnt != 8'h00) begin
				n.cnt = r.cnt - 8'h01;
			end else begin
				// Rising write strobe with address and data still held
				n.ph = bfcs_pkg::PH_END;
				n.we_n = 1'b1; // R25
				if (!r.wr) begin
					n.rdata = r.s2;
				end
			end
			bfcs_pkg::PH_END: begin
				n.ph = bfcs_pkg::PH_IDLE;
				n.ce_n = 1'b1; // R20
				n.oe_n = 1'b1;
				n.dq_oe = 1'b0;
				n.done = 1'b1;
			end
			default: n = BC_RST;
		endcase
	end

	// Register the state
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			r <= BC_RST;
		end else begin
			r <= n;
		end
	end

	assign ce_n = r.ce_n;
	assign we_n = r.we_n;
	assign oe_n = r.oe_n;
	assign addr_o = r.addr;
	assign dq_o = r.dq_o;
	assign dq_oe = r.dq_oe;
	assign rdata = r.rdata;
	assign done = r.done;

	// =====================================================
	// Checks
	AST_ADDR_STABLE: assert property (@(posedge mclk) disable iff (sys_rst) // R5
		(r.ph == bfcs_pkg::PH_STROBE || r.ph == bfcs_pkg::PH_END) |-> $stable(addr_o))
		else $error("address moved inside a bus cycle");
	AST_WE_WIDTH: assert property (@(posedge mclk) disable iff (sys_rst) // R6
		$fell(we_n) |-> (!we_n && dq_oe && !ce_n) [*2] ##1 (we_n && dq_oe))
		else $error("write strobe width or data hold wrong");
	AST_NO_CLASH: assert property (@(posedge mclk) disable iff (sys_rst) // R25
		!oe_n |-> !dq_oe && we_n)
		else $error("data bus driven during a read");
endmodule // bfcs_bus_cycle

// ### logic/bfcs_host.sv
// Host controller for a boot-block flash: AXI4-Lite registers in, flash pins out.
// Assumes one clock (mclk) and a flash that answers on the data pins asynchronously.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
module bfcs_host (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [bfcs_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [bfcs_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [18:0] flash_addr,
	output logic [15:0] flash_dq_o,
	output logic flash_dq_oe,
	input wire logic [15:0] flash_dq_i,
	output logic flash_ce_n,
	output logic flash_we_n,
	output logic flash_oe_n,
	output logic reset_powerdown_n,
	output logic flash_wp
);
	// =====================================================
	// State
	typedef struct packed {
		bfcs_pkg::bfcs_st_t st;
		logic lau;            // Bus cycle launched for this state
		logic [7:0] cnt;      // Reset timing countdown
		logic [3:0] op, pop;  // Running and pending operation
		logic pend;           // Command waiting for idle
		logic [7:0] cmd1;     // First-cycle command code
		logic [18:0] addr, eaddr;
		logic [15:0] wdata;
		logic [bfcs_pkg::CTRL_W-1:0] ctrl;
		logic [31:0] rdata;
		logic [7:0] sr;       // Last flash status byte
		logic [2:0] err;      // Sticky erase, write, supply errors
		logic susp, refused, sreq, rp_n, wp;
		logic aw_got, w_got, awrdy, wrdy, bvalid, arrdy, rvalid;
		logic [bfcs_pkg::AXI_AW-1:0] awa;
		logic [31:0] wd;
		logic [3:0] ws;
		logic [1:0] bresp, rresp;
		logic [31:0] rdat;
	} bfcs_ctl_t;
	// Reset holds the flash in reset for a full pulse, as at power-up
	localparam bfcs_ctl_t CTL_RST = '{st: bfcs_pkg::ST_RST_LO, cnt: 8'(bfcs_pkg::RP_CYC - 1),
		default: '0};
	bfcs_ctl_t r, n;
	logic eng_start, eng_wr, eng_done, refuse, late_cmd;
	logic [18:0] eng_addr;
	logic [15:0] eng_wdata, eng_rd;
	logic [5:0] blk_req, blk_erase;

	// Byte-lane merge of a register write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// Operations allowed while an erase is suspended
	function automatic logic susp_ok(input logic [3:0] op);
		return op == bfcs_pkg::OP_READ || op == bfcs_pkg::OP_READ_ARRAY ||
			op == bfcs_pkg::OP_STATUS || op == bfcs_pkg::OP_RESUME || op == bfcs_pkg::OP_RESET;
	endfunction

	// First-cycle command code of an operation
	function automatic logic [7:0] op_code(input logic [3:0] op, input logic alt);
		case (op)
			bfcs_pkg::OP_IDENTIFY: return bfcs_pkg::CMD_IDENTIFY;
			bfcs_pkg::OP_STATUS: return bfcs_pkg::CMD_READ_STATUS;
			bfcs_pkg::OP_CLEAR: return bfcs_pkg::CMD_CLEAR_STATUS;
			bfcs_pkg::OP_PROGRAM: return alt ? bfcs_pkg::CMD_WRITE_ALT : bfcs_pkg::CMD_WRITE_SETUP;
			bfcs_pkg::OP_ERASE: return bfcs_pkg::CMD_ERASE_SETUP;
			bfcs_pkg::OP_RESUME: return bfcs_pkg::CMD_CONFIRM;
			default: return bfcs_pkg::CMD_READ_ARRAY;
		endcase
	endfunction

	// =====================================================
	// Flash bus cycle engine
	bfcs_bus_cycle u_cycle (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.start(eng_start),
		.wr(eng_wr),
		.addr(eng_addr),
		.wdata(eng_wdata),
		.pin_dq_i(flash_dq_i),
		.ce_n(flash_ce_n),
		.we_n(flash_we_n),
		.oe_n(flash_oe_n),
		.addr_o(flash_addr),
		.dq_o(flash_dq_o),
		.dq_oe(flash_dq_oe),
		.rdata(eng_rd),
		.done(eng_done)
	);

	assign blk_req = bfcs_pkg::block_of(r.addr, r.ctrl[bfcs_pkg::CTRL_BYTE]);
	assign blk_erase = bfcs_pkg::block_of(r.eaddr, r.ctrl[bfcs_pkg::CTRL_BYTE]);

	// =====================================================
	// Next state: register bus, then sequencer
	always_comb begin
		n = r;
		n.wp = r.ctrl[bfcs_pkg::CTRL_WP]; // R12
		eng_start = 1'b0;
		eng_wr = 1'b0;
		eng_addr = r.addr;
		eng_wdata = {8'h00, r.cmd1};
		late_cmd = 1'b0;
		// Refusals keep the flash from seeing a sequence it would reject
		refuse = r.susp ? (!susp_ok(r.pop) || (r.pop == bfcs_pkg::OP_READ && blk_req == blk_erase)) // R15
			: (r.pop == bfcs_pkg::OP_RESUME || r.pop == bfcs_pkg::OP_SUSPEND);
		if (r.err[0] && (r.pop == bfcs_pkg::OP_PROGRAM || r.pop == bfcs_pkg::OP_ERASE)) begin
			refuse = 1'b1; // R18
		end
		// Write channels, taken in either order
		if (s_axi_awvalid && r.awrdy) begin
			n.aw_got = 1'b1;
			n.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && r.wrdy) begin
			n.w_got = 1'b1;
			n.wd = s_axi_wdata;
			n.ws = s_axi_wstrb;
		end
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (r.aw_got && r.w_got && !r.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = bfcs_pkg::RESP_OKAY;
			case ({r.awa[bfcs_pkg::AXI_AW-1:2], 2'b00})
				bfcs_pkg::OFF_CMD: if (r.ws[0]) begin
					// Suspend is the one order taken while an erase runs
					if (r.wd[3:0] == bfcs_pkg::OP_SUSPEND && r.st == bfcs_pkg::ST_POLL &&
						r.op == bfcs_pkg::OP_ERASE) begin
						n.sreq = 1'b1; // R13
					end else if (r.st == bfcs_pkg::ST_IDLE && !r.pend) begin
						n.pend = 1'b1;
						n.pop = r.wd[3:0];
					end else begin
						n.refused = 1'b1; // R24
						late_cmd = 1'b1;
					end
				end
				bfcs_pkg::OFF_ADDR: n.addr = 19'(merge({13'h0000, r.addr}, r.wd, r.ws));
				bfcs_pkg::OFF_WDATA: n.wdata = 16'(merge({16'h0000, r.wdata}, r.wd, r.ws));
				bfcs_pkg::OFF_CTRL: n.ctrl = bfcs_pkg::CTRL_W'(merge(32'(r.ctrl), r.wd, r.ws));
				bfcs_pkg::OFF_STATUS, bfcs_pkg::OFF_RDATA: n.bresp = bfcs_pkg::RESP_OKAY;
				default: n.bresp = bfcs_pkg::RESP_SLVERR;
			endcase
		end
		// Read channel
		if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && r.arrdy) begin
			n.rvalid = 1'b1;
			n.rresp = bfcs_pkg::RESP_OKAY;
			n.rdat = 32'h0000_0000;
			case ({s_axi_araddr[bfcs_pkg::AXI_AW-1:2], 2'b00})
				bfcs_pkg::OFF_CMD: n.rdat[3:0] = r.op;
				bfcs_pkg::OFF_ADDR: n.rdat[18:0] = r.addr;
				bfcs_pkg::OFF_WDATA: n.rdat[15:0] = r.wdata;
				bfcs_pkg::OFF_CTRL: n.rdat[bfcs_pkg::CTRL_W-1:0] = r.ctrl;
				bfcs_pkg::OFF_STATUS: begin
					n.rdat[7:0] = r.sr;
					n.rdat[bfcs_pkg::SB_BUSY] = r.pend || (r.st != bfcs_pkg::ST_IDLE && r.st != bfcs_pkg::ST_PD);
					n.rdat[bfcs_pkg::SB_SUSP] = r.susp;
					n.rdat[bfcs_pkg::SB_REF] = r.refused;
					n.rdat[bfcs_pkg::SB_ERR +: 3] = r.err;
					n.rdat[bfcs_pkg::SB_SEQ] = r.err[2] && r.err[1]; // R19
				end
				bfcs_pkg::OFF_RDATA: n.rdat = r.rdata;
				default: n.rresp = bfcs_pkg::RESP_SLVERR;
			endcase
		end
		n.awrdy = !n.aw_got && !n.bvalid;
		n.wrdy = !n.w_got && !n.bvalid;
		n.arrdy = !n.rvalid;
		// Sequencer: each bus state launches one cycle, then waits for done
		case (r.st)
			bfcs_pkg::ST_RST_LO: begin
				n.rp_n = 1'b0; // R22
				if (r.cnt != 8'h00) begin
					n.cnt = r.cnt - 8'h01;
				end else begin
					n.st = bfcs_pkg::ST_RST_HI;
					n.rp_n = 1'b1;
					n.cnt = 8'(bfcs_pkg::RWH_CYC - 1);
				end
			end
			bfcs_pkg::ST_RST_HI: if (r.cnt != 8'h00) begin
				n.cnt = r.cnt - 8'h01;
			end else begin
				n.st = bfcs_pkg::ST_IDLE;
			end
			bfcs_pkg::ST_PD: if (!r.ctrl[bfcs_pkg::CTRL_PD]) begin
				// Leave power-down through a full reset pulse
				n.st = bfcs_pkg::ST_RST_LO;
				n.cnt = 8'(bfcs_pkg::RP_CYC - 1);
			end
			bfcs_pkg::ST_IDLE: if (r.ctrl[bfcs_pkg::CTRL_PD]) begin
				n.st = bfcs_pkg::ST_PD;
				n.rp_n = 1'b0; // R20
				n.sr = 8'h00; // R21
				n.err = 3'h0;
				n.susp = 1'b0;
			end else if (r.pend) begin
				n.pend = 1'b0;
				n.op = r.pop;
				n.refused = refuse || late_cmd; // A refusal in this same cycle wins
				n.cmd1 = op_code(r.pop, r.ctrl[bfcs_pkg::CTRL_ALT]); // R6
				if (!refuse) begin
					case (r.pop)
						bfcs_pkg::OP_READ: n.st = bfcs_pkg::ST_RD;
						bfcs_pkg::OP_RESET: begin
							n.st = bfcs_pkg::ST_RST_LO;
							n.rp_n = 1'b0; // R22
							n.cnt = 8'(bfcs_pkg::RP_CYC - 1);
							n.sr = 8'h00; // R21
							n.err = 3'h0;
							n.susp = 1'b0;
						end
						default: n.st = bfcs_pkg::ST_WR1;
					endcase
					if (r.pop == bfcs_pkg::OP_ERASE) begin
						n.eaddr = r.addr;
					end
					if (r.pop == bfcs_pkg::OP_CLEAR) begin
						n.err = 3'h0; // R17
						n.sr = 8'h00;
					end
				end
			end
			bfcs_pkg::ST_WR1, bfcs_pkg::ST_WR2, bfcs_pkg::ST_SUSP, bfcs_pkg::ST_ARRAY: begin
				eng_wr = 1'b1;
				if (r.st == bfcs_pkg::ST_WR2) begin
					// Second cycle carries target data, or confirm inside the block
					eng_wdata = (r.op == bfcs_pkg::OP_ERASE) ? {8'h00, bfcs_pkg::CMD_CONFIRM} : r.wdata; // R7
					eng_addr = (r.op == bfcs_pkg::OP_ERASE) ? r.eaddr : r.addr; // R4
				end
				if (r.st == bfcs_pkg::ST_ARRAY) begin
					eng_wdata = {8'h00, bfcs_pkg::CMD_READ_ARRAY}; // R1
				end
				if (!r.lau) begin
					eng_start = 1'b1;
					n.lau = 1'b1;
				end else if (eng_done) begin
					n.lau = 1'b0;
					n.st = bfcs_pkg::ST_IDLE;
					if (r.st == bfcs_pkg::ST_WR2 || r.st == bfcs_pkg::ST_SUSP) begin
						n.st = bfcs_pkg::ST_POLL;
					end else if (r.st == bfcs_pkg::ST_WR1) begin
						case (r.op)
							bfcs_pkg::OP_PROGRAM, bfcs_pkg::OP_ERASE: n.st = bfcs_pkg::ST_WR2;
							bfcs_pkg::OP_IDENTIFY: n.st = bfcs_pkg::ST_ID0; // R2
							bfcs_pkg::OP_STATUS: n.st = bfcs_pkg::ST_RD; // R3
							bfcs_pkg::OP_RESUME: begin
								n.st = bfcs_pkg::ST_POLL; // R16
								n.op = bfcs_pkg::OP_ERASE;
								n.susp = 1'b0;
							end
							default: n.st = bfcs_pkg::ST_IDLE;
						endcase
					end
				end
			end
			bfcs_pkg::ST_RD, bfcs_pkg::ST_ID0, bfcs_pkg::ST_ID1, bfcs_pkg::ST_POLL: begin
				if (r.st == bfcs_pkg::ST_ID0) begin
					eng_addr = bfcs_pkg::IA_MFR;
				end
				if (r.st == bfcs_pkg::ST_ID1) begin
					eng_addr = bfcs_pkg::IA_DEV;
				end
				if (!r.lau) begin
					eng_start = 1'b1;
					n.lau = 1'b1;
				end else if (eng_done) begin
					n.lau = 1'b0;
					if (r.st == bfcs_pkg::ST_ID0) begin
						n.rdata[15:0] = eng_rd;
						n.st = bfcs_pkg::ST_ID1;
					end else if (r.st == bfcs_pkg::ST_ID1) begin
						n.rdata[31:16] = eng_rd;
						n.st = bfcs_pkg::ST_ARRAY;
					end else if (r.st == bfcs_pkg::ST_RD) begin
						n.rdata = {16'h0000, eng_rd};
						n.st = bfcs_pkg::ST_IDLE;
						if (r.op == bfcs_pkg::OP_STATUS) begin
							n.sr = eng_rd[7:0]; // R3
							if (eng_rd[bfcs_pkg::SR_READY]) begin
								n.err = r.err | eng_rd[bfcs_pkg::SR_ERASE:bfcs_pkg::SR_SUPPLY]; // R23
							end
						end
					end else begin
						// Reads during a busy program or erase return the status byte
						n.sr = eng_rd[7:0]; // R10
						if (eng_rd[bfcs_pkg::SR_READY]) begin
							n.err = r.err | eng_rd[bfcs_pkg::SR_ERASE:bfcs_pkg::SR_SUPPLY]; // R23
							if (r.op == bfcs_pkg::OP_SUSPEND && eng_rd[bfcs_pkg::SR_SUSP]) begin
								n.susp = 1'b1; // R14
								n.st = bfcs_pkg::ST_IDLE;
							end else begin
								n.st = bfcs_pkg::ST_ARRAY; // R1
							end
						end else if (r.sreq && r.op == bfcs_pkg::OP_ERASE) begin
							n.sreq = 1'b0;
							n.op = bfcs_pkg::OP_SUSPEND;
							n.cmd1 = bfcs_pkg::CMD_SUSPEND; // R13
							n.st = bfcs_pkg::ST_SUSP;
						end
					end
				end
			end
			default: n = CTL_RST;
		endcase
		if (n.st != bfcs_pkg::ST_POLL) begin
			n.sreq = 1'b0;
		end
	end

	// Register the state
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			r <= CTL_RST;
		end else begin
			r <= n;
		end
	end

	assign s_axi_awready = r.awrdy;
	assign s_axi_wready = r.wrdy;
	assign s_axi_bresp = r.bresp;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_arready = r.arrdy;
	assign s_axi_rdata = r.rdat;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rvalid = r.rvalid;
	assign reset_powerdown_n = r.rp_n;
	assign flash_wp = r.wp;

	// =====================================================
	// Checks
	AST_RP_WIDTH: assert property (@(posedge mclk) disable iff (sys_rst) // R22
		$rose(reset_powerdown_n) |-> !$past(reset_powerdown_n, 3))
		else $error("reset pulse shorter than three cycles");
	AST_STATUS_SEQ: assert property (@(posedge mclk) disable iff (sys_rst) // R3
		(r.st == bfcs_pkg::ST_WR1 && r.op == bfcs_pkg::OP_STATUS && eng_done) |=> r.st == bfcs_pkg::ST_RD)
		else $error("status command not followed by a read");
	AST_FF_AFTER: assert property (@(posedge mclk) disable iff (sys_rst) // R1
		(r.st == bfcs_pkg::ST_POLL && eng_done && eng_rd[7] && r.op != bfcs_pkg::OP_SUSPEND)
		|=> r.st == bfcs_pkg::ST_ARRAY ##[1:40] r.st == bfcs_pkg::ST_IDLE)
		else $error("no read-array after completion");
	AST_CONFIRM: assert property (@(posedge mclk) disable iff (sys_rst) // R7
		(r.st == bfcs_pkg::ST_WR2 && eng_start && r.op == bfcs_pkg::OP_ERASE)
		|-> eng_wdata[7:0] == bfcs_pkg::CMD_CONFIRM && eng_addr == r.eaddr)
		else $error("erase confirm wrong");
	AST_PROG_DATA: assert property (@(posedge mclk) disable iff (sys_rst) // R6
		(r.st == bfcs_pkg::ST_WR2 && eng_start && r.op == bfcs_pkg::OP_PROGRAM)
		|-> eng_wdata == r.wdata && eng_addr == r.addr)
		else $error("program data cycle wrong");
	AST_ID_ADDR: assert property (@(posedge mclk) disable iff (sys_rst) // R2
		(r.st == bfcs_pkg::ST_ID1 && eng_start) |-> eng_addr == bfcs_pkg::IA_DEV && r.rdata[15:0] == $past(eng_rd, 2))
		else $error("identify address wrong");
	AST_SUSP_REFUSE: assert property (@(posedge mclk) disable iff (sys_rst) // R15
		(r.st == bfcs_pkg::ST_IDLE && r.pend && r.susp && r.pop == bfcs_pkg::OP_PROGRAM && !r.ctrl[bfcs_pkg::CTRL_PD])
		|=> r.refused && r.st == bfcs_pkg::ST_IDLE)
		else $error("program taken while suspended");
	AST_SUPPLY_BLOCK: assert property (@(posedge mclk) disable iff (sys_rst) // R18
		(r.st == bfcs_pkg::ST_IDLE && r.pend && r.err[0] && r.pop == bfcs_pkg::OP_ERASE && !r.ctrl[bfcs_pkg::CTRL_PD])
		|=> r.refused && r.st == bfcs_pkg::ST_IDLE)
		else $error("erase taken with supply missing");
endmodule // bfcs_host

// ### logic/bfcs_pkg.sv
// Constants, types and helpers for the boot flash host controller.
// Assumes mclk at 20 MHz and a flash part wired straight to the pin ports.
// Contract
// [R1] Send read-array after program or erase ends.
// [R2] Identify reads: address 00h maker, 01h device.
// [R3] Read-status command, then next read gives status.
// [R4] Erase block from A12-A17 or A13-A18.
// [R5] Keep first-cycle address stable whole cycle.
// [R6] Program: setup 40h/10h, then address and data.
// [R7] Erase: 20h, then D0h inside the block.
// [R8] Erased block reads all ones.
// [R9] Bad confirm sets write and erase errors.
// [R10] Reads during erase return status.
// [R11] Erase done sets ready, stays status mode.
// [R12] Boot block erase needs protect pin or high reset.
// [R13] During erase only suspend is accepted.
// [R14] Suspend sets suspended and ready flags.
// [R15] Suspended: array, resume, status only; not erased block.
// [R16] Early resume continues erase directly.
// [R17] Error flags cleared only by clear or reset.
// [R18] Supply missing blocks program and erase.
// [R19] Both erase and write errors: sequencing error.
// [R20] Reset low: power-down; chip enable high: standby.
// [R21] Reset clears status, starts in array read.
// [R22] Hold reset low at power-up, or pulse it.
// [R23] Error flags valid only while ready reads one.
// [R24] Program ignores commands, then status mode.
// [R25] Command captured on write enable rising edge.
// [R26] Status flags change only on clock edges.
package bfcs_pkg;
	// =====================================================
	// Timing
	localparam int CLK_NS = 50;     // mclk period
	localparam int T_WE_NS = 60;    // Write strobe low time
	localparam int T_ACC_NS = 80;   // Access time from enables
	localparam int T_RP_NS = 150;   // Reset low pulse width
	localparam int T_RWH_NS = 1000; // Reset high to valid output
	localparam int SYNC_CYC = 2;    // Read data synchroniser depth
	// Least times round up
	function automatic int cyc_min(input int ns);
		return (ns + CLK_NS - 1) / CLK_NS;
	endfunction
	localparam int WE_CYC = cyc_min(T_WE_NS);
	localparam int ACC_CYC = cyc_min(T_ACC_NS);
	localparam int RP_CYC = cyc_min(T_RP_NS);
	localparam int RWH_CYC = cyc_min(T_RWH_NS);
	// =====================================================
	// Flash command codes
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_IDENTIFY = 8'h90;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
	localparam logic [7:0] CMD_WRITE_ALT = 8'h10;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [18:0] IA_MFR = 19'h0_0000;
	localparam logic [18:0] IA_DEV = 19'h0_0001;
	// Flash status byte bits
	localparam int SR_READY = 7;
	localparam int SR_SUSP = 6;
	localparam int SR_ERASE = 5;
	localparam int SR_SUPPLY = 3;
	// =====================================================
	// Software register map
	localparam int AXI_AW = 8;
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_WDATA = 8'h08;
	localparam logic [7:0] OFF_CTRL = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_RDATA = 8'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Control bits
	localparam int CTRL_W = 4;
	localparam int CTRL_WP = 0;
	localparam int CTRL_BYTE = 1;
	localparam int CTRL_PD = 2;
	localparam int CTRL_ALT = 3;
	// Status word fields above the flash byte
	localparam int SB_BUSY = 8;
	localparam int SB_SUSP = 9;
	localparam int SB_REF = 10;
	localparam int SB_ERR = 11;
	localparam int SB_SEQ = 14;
	// Operation codes written to the command register
	localparam logic [3:0] OP_READ = 4'h0;
	localparam logic [3:0] OP_READ_ARRAY = 4'h1;
	localparam logic [3:0] OP_IDENTIFY = 4'h2;
	localparam logic [3:0] OP_STATUS = 4'h3;
	localparam logic [3:0] OP_CLEAR = 4'h4;
	localparam logic [3:0] OP_PROGRAM = 4'h5;
	localparam logic [3:0] OP_ERASE = 4'h6;
	localparam logic [3:0] OP_SUSPEND = 4'h7;
	localparam logic [3:0] OP_RESUME = 4'h8;
	localparam logic [3:0] OP_RESET = 4'h9;
	// =====================================================
	// Types
	typedef enum logic [2:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_END} bfcs_ph_t;
	typedef enum logic [3:0] {ST_RST_LO, ST_RST_HI, ST_PD, ST_IDLE, ST_WR1, ST_WR2,
		ST_RD, ST_ID0, ST_ID1, ST_POLL, ST_SUSP, ST_ARRAY} bfcs_st_t;
	// Erase block number from an address
	function automatic logic [5:0] block_of(input logic [18:0] a, input logic byte_mode);
		return byte_mode ? a[18:13] : a[17:12]; // R4
	endfunction
endpackage

// ### verification/bfcs_flash_model.sv
// Behavioural boot-block flash that sits on the pins of the host controller.
// Assumes commands arrive on we_n rising edges while ce_n is low.
module bfcs_flash_model #(
	parameter logic [15:0] MFR = 16'h00a5, // Arbitrary value
	parameter logic [15:0] DEV = 16'h003c // Arbitrary value
) (
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic rst_n,
	input wire logic wp,
	input wire logic [18:0] a,
	input wire logic [15:0] d,
	output logic [15:0] q
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// State
	logic [7:0] sr; // Status byte
	logic [1:0] md; // 0 array, 1 identify, 2 status
	logic [7:0] su; // Pending setup code
	logic [15:0] v; // Value offered while enabled
	logic [15:0] lv; // Last value offered
	// Command capture; busy ends after a fixed delay
	always @(posedge we_n or negedge rst_n)
		if (!rst_n) begin
			sr <= 8'h80;
			md <= 0;
			su <= 0;
		end else if (!ce_n) begin
			if (su != 0) begin
				su <= 0;
				md <= 2;
				if (su == 8'h20 && d[7:0] != 8'hd0) sr[5:4] <= 2'b11;
				else if (su == 8'h20 && a[17:12] == 0 && !wp) sr[5] <= 1;
				else if (su == 8'h10) sr[3] <= 1;
				else begin
					sr[7] <= 0;
					sr[7] <= #(su == 8'h20 ? 3000 : 300) 1'b1;
				end
			end else if (!sr[7]) begin
				if (d[7:0] == 8'hb0) sr[7:6] <= #100 2'b11;
			end else case (d[7:0])
				8'hff: md <= 0;
				8'h90: md <= 1;
				8'h70: md <= 2;
				8'h50: sr[5:3] <= 0;
				8'hd0: if (sr[6]) begin
					sr[7:6] <= 0;
					sr[7] <= #1000 1'b1;
				end
				8'h40, 8'h10, 8'h20: su <= d[7:0];
				default: ;
			endcase
		end
	// Status on every read while busy; array is a fixed pattern
	always_comb v = (!sr[7] || md == 2) ? {8'h00, sr} : md == 1 ? (a[0] ? DEV : MFR) : a[15:0] ^ 16'h5a5a;
	// Released pins show the inverse so a stale value never passes
	always @(v or ce_n or oe_n) if (!ce_n && !oe_n) lv = v;
	assign q = (ce_n || oe_n) ? ~lv : v;
endmodule // bfcs_flash_model

// ### verification/testbench.sv
// Self-checking bench: AXI4-Lite master, host controller, flash model.
// Assumes the controller sets busy before answering a command write.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Signals
	localparam logic [15:0] MFR = 16'h00a5; // Arbitrary value
	localparam logic [15:0] DEV = 16'h003c; // Arbitrary value
	logic mclk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n;
	logic reset_powerdown_n, flash_wp;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic [18:0] flash_addr;
	logic [15:0] flash_dq_o, flash_dq_i, fq;
	int mismatches = 0, total_checks = 0;
	int unsigned x;
	initial forever #25 mclk = ~mclk;
	assign flash_dq_i = flash_dq_oe ? flash_dq_o : fq;
	bfcs_host i_dut (.*);
	bfcs_flash_model #(.MFR(MFR), .DEV(DEV)) i_flash (.ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n),
		.rst_n(reset_powerdown_n), .wp(flash_wp), .a(flash_addr), .d(flash_dq_o), .q(fq));
	// ==========================================
	// Tasks
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	// One AXI write or read; each channel drops valid once taken
	task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
		int n;
		bit p, c, b;
		@(posedge mclk);
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1;
			s_axi_wvalid <= 1;
			s_axi_bready <= 1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1;
			s_axi_rready <= 1;
		end
		p = w;
		c = 1;
		b = 0;
		for (n = 0; n < 99 && !b; n++) begin
			@(posedge mclk);
			if (p && s_axi_awready) begin
				p = 0;
				s_axi_awvalid <= 0;
			end
			if (c && (w ? s_axi_wready : s_axi_arready)) begin
				c = 0;
				s_axi_wvalid <= 0;
				s_axi_arvalid <= 0;
			end
			b = w ? s_axi_bvalid : s_axi_rvalid;
			rsp = w ? s_axi_bresp : s_axi_rresp;
			v = s_axi_rdata;
		end
		s_axi_bready <= 0;
		s_axi_rready <= 0;
		if (!b) begin
			mismatches++;
			summarize();
		end
	endtask
	// Command write, then poll busy under a bound
	task automatic op(input logic [3:0] k);
		int n;
		bus(1, bfcs_pkg::OFF_CMD, {28'h0, k});
		for (n = 0; n < 200; n++) begin
			bus(0, bfcs_pkg::OFF_STATUS, 0);
			if (v[8] === 1'b0) return;
		end
		mismatches++;
		summarize();
	endtask
	// ==========================================
	// Scenarios
	initial begin
		x = $urandom(32'hb2b1e2e8);
		repeat (10) @(posedge mclk);
		sys_rst <= 0;
		repeat (30) @(posedge mclk);
		op(bfcs_pkg::OP_IDENTIFY);
		bus(0, bfcs_pkg::OFF_RDATA, 0);
		chk(v, {DEV, MFR});
		x = $urandom;
		bus(1, bfcs_pkg::OFF_ADDR, {13'h0, x[18:0]});
		bus(1, bfcs_pkg::OFF_WDATA, $urandom);
		op(bfcs_pkg::OP_PROGRAM);
		chk(v[13:7], 7'h01);
		op(bfcs_pkg::OP_READ);
		bus(0, bfcs_pkg::OFF_RDATA, 0);
		chk(v[15:0], x[15:0] ^ 16'h5a5a);
		op(bfcs_pkg::OP_STATUS);
		bus(0, bfcs_pkg::OFF_RDATA, 0);
		chk(v[7:0], 8'h80);
		bus(1, bfcs_pkg::OFF_ADDR, 0);
		op(bfcs_pkg::OP_ERASE);
		chk(v[13:11], 3'b100);
		op(bfcs_pkg::OP_READ_ARRAY);
		chk(v[13:11], 3'b100);
		op(bfcs_pkg::OP_CLEAR);
		chk(v[13:11], 3'b000);
		bus(1, bfcs_pkg::OFF_CTRL, 32'h0000_0009);
		op(bfcs_pkg::OP_PROGRAM);
		chk(v[13:11], 3'b001);
		op(bfcs_pkg::OP_ERASE);
		chk(v[13:10], 4'b0011);
		op(bfcs_pkg::OP_CLEAR);
		bus(1, bfcs_pkg::OFF_CTRL, 32'h0000_0001);
		op(bfcs_pkg::OP_ERASE);
		chk(v[13:7], 7'h01);
		bus(1, bfcs_pkg::OFF_ADDR, 32'h0002_0000);
		bus(1, bfcs_pkg::OFF_CMD, {28'h0, bfcs_pkg::OP_ERASE});
		repeat (30) @(posedge mclk);
		op(bfcs_pkg::OP_SUSPEND);
		chk(v[9], 1'b1);
		op(bfcs_pkg::OP_PROGRAM);
		chk(v[10:9], 2'b11);
		op(bfcs_pkg::OP_RESUME);
		chk({v[9], v[7]}, 2'b01);
		op(bfcs_pkg::OP_RESET);
		chk(v[13:7], 7'h00);
		bus(0, 8'h40, 0);
		chk(rsp, bfcs_pkg::RESP_SLVERR);
		summarize();
	end
endmodule // testbench
